// ### isr_pkg.sv
`default_nettype none
package isr_pkg;
  // Operation group bit positions
  localparam int OPER_CAL_BIT = 0;
  localparam int OPER_SWEEP_BIT = 3;
  localparam int OPER_AVG_BIT = 8;
  localparam int OPER_PROG_BIT = 14;
  localparam int DEV_FAN_BIT = 0;
  // Power group: overload at 2*n, trip at 2*n+1
  localparam int PWR_INPUTS = 3;
  localparam int FRQ_LO1_BIT = 0;
  localparam int FRQ_LO2_BIT = 1;
  localparam int FRQ_SYN_BIT = 2;
  localparam int FRQ_EXT_BIT = 3;
  localparam int FRQ_VCXO_BIT = 4;
  localparam int LIM_BITS = 8;
  // Status byte positions
  localparam int STB_DEV_BIT = 2;
  localparam int STB_QUESTIONABLE_SUMMARY_BIT_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  // Reset values
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [15:0] EN_RST = 16'h0000;
  // Enable register select codes
  localparam logic [2:0] EN_SEL_OPER = 3'h0;
  localparam logic [2:0] EN_SEL_DEV = 3'h1;
  localparam logic [2:0] EN_SEL_PWR = 3'h2;
  localparam logic [2:0] EN_SEL_FRQ = 3'h3;
  localparam logic [2:0] EN_SEL_LIM = 3'h4;
  localparam logic [2:0] EN_SEL_SRE = 3'h5;

  typedef enum logic {REQ_OFF = 1'b0, REQ_ON = 1'b1} isr_req_t;

  typedef struct packed {
    logic prog_run;
    logic sweeping;
    logic calibrating;
    logic fan_stopped;
    logic [2:0] overload;
    logic [2:0] tripped;
    logic [1:0] lo_unlock;
    logic synth_unlock;
    logic ext_ref;
    logic vcxo_unlock;
    logic [7:0] limit_fail;
  } isr_pins_t;

  typedef struct packed {
    logic cls;
    logic legacy_mode;
    logic request_enable_cmd;
    logic request_disable_cmd;
    logic query_rcv;
    logic resp_out;
    logic serial_poll;
    logic interp_wr;
    logic [7:0] interp_val;
  } isr_cmd_t;

  typedef struct packed {
    logic oper;
    logic dev;
    logic pwr;
    logic frq;
    logic lim;
  } isr_rd_t;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [15:0] data;
  } isr_en_wr_t;
endpackage
`default_nettype wire

// ### isr_status.sv
//Function
//- Operation condition: program, sweep, calibrate bits only
//- Operation condition averaging bit reads zero
//- Operation events latch falling condition edges
//- Averaging completion sets operation event bit 8
//- Device condition bit 0 shows fan stopped
//- Power bits 0,2,4 show input overloads
//- Power bits 1,3,5 show protection trips
//- Power events latch rising condition edges
//- Frequency bits 0,1,2,4 show lock losses
//- Frequency bit 3 shows external reference
//- Frequency events latch rising condition edges
//- Limit bits: even first, odd second trace
//- Limit events latch rising condition edges
//- Legacy enable only reacts to new summary
//- Request disable stops summary requests in legacy mode only
//- Disable then enable drops pending request
//- Serial poll clears request; query leaves summary
//- Polled byte shows most recently stored value
//- Interpreter write immediate; internal on change only
//- Group masks gate only the summary bits, never the queue bit
//- Queue bit set on query, cleared on output
//- Query after interpreter write overrides polled byte
//- Clear-status leaves polled byte unless change
//- Group summary is OR of event AND enable
//- Events held until read or clear-status
//- Operation summary drives status bit 7
//- Device summary drives status bit 2
`default_nettype none
module isr_status
  import isr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire isr_pins_t pins_i,
  input wire logic avg_done_i,
  input wire logic esb_i,
  input wire logic questionable_summary_bit_i,
  input wire isr_cmd_t cmd_i,
  input wire isr_rd_t rd_i,
  input wire isr_en_wr_t en_wr_i,
  output logic [15:0] oper_cond_o,
  output logic [15:0] oper_evt_o,
  output logic [15:0] dev_cond_o,
  output logic [15:0] dev_evt_o,
  output logic [15:0] pwr_cond_o,
  output logic [15:0] pwr_evt_o,
  output logic [15:0] frq_cond_o,
  output logic [15:0] frq_evt_o,
  output logic [7:0] lim_cond_o,
  output logic [7:0] lim_evt_o,
  output logic [2:0] grp_sum_o,
  output logic [7:0] stb_o,
  output logic [7:0] polled_o,
  output logic srq_o
);
  isr_pins_t pins_s1_reg;
  isr_pins_t pins_s2_reg;
  logic [15:0] oper_cond_reg, oper_cond_next;
  logic [15:0] dev_cond_reg, dev_cond_next;
  logic [15:0] pwr_cond_reg, pwr_cond_next;
  logic [15:0] frq_cond_reg, frq_cond_next;
  logic [7:0] lim_cond_reg, lim_cond_next;
  logic [15:0] oper_evt_reg, dev_evt_reg, pwr_evt_reg, frq_evt_reg;
  logic [7:0] lim_evt_reg;
  logic [15:0] oper_en_reg, dev_en_reg, pwr_en_reg, frq_en_reg, lim_en_reg;
  logic [7:0] sre_reg;
  logic [15:0] oper_set, dev_set, pwr_set, frq_set;
  logic [7:0] lim_set;
  logic [2:0] grp_sum_reg;
  logic mav_reg;
  logic [7:0] stb_reg, stb_next;
  logic [7:0] polled_reg, polled_next;
  logic stb_changed, mss_rise;
  isr_req_t req_reg;

  function automatic logic summary(input logic [15:0] evt,
                                   input logic [15:0] en);
    summary = |(evt & en);
  endfunction

  function automatic logic [15:0] rising(input logic [15:0] now,
                                         input logic [15:0] was);
    rising = now & ~was;
  endfunction

  function automatic logic [15:0] event_next(input logic [15:0] evt,
                                             input logic [15:0] set,
                                             input logic clr);
    event_next = (clr ? REG16_RST : evt) | set;
  endfunction

  // Pins are asynchronous to clock_i
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pins_s1_reg <= '0;
      pins_s2_reg <= '0;
    end else if (ce_i) begin
      pins_s1_reg <= pins_i;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  always_comb begin
    oper_cond_next = REG16_RST;
    oper_cond_next[OPER_PROG_BIT] = pins_s2_reg.prog_run;
    oper_cond_next[OPER_SWEEP_BIT] = pins_s2_reg.sweeping;
    oper_cond_next[OPER_CAL_BIT] = pins_s2_reg.calibrating;
    // Averaging has no condition source
    dev_cond_next = REG16_RST;
    dev_cond_next[DEV_FAN_BIT] = pins_s2_reg.fan_stopped;
    pwr_cond_next = REG16_RST;
    for (int i = 0; i < PWR_INPUTS; i++) begin
      pwr_cond_next[2 * i] = pins_s2_reg.overload[i];
      pwr_cond_next[2 * i + 1] = pins_s2_reg.tripped[i];
    end
    frq_cond_next = REG16_RST;
    frq_cond_next[FRQ_LO1_BIT] = pins_s2_reg.lo_unlock[0];
    frq_cond_next[FRQ_LO2_BIT] = pins_s2_reg.lo_unlock[1];
    frq_cond_next[FRQ_SYN_BIT] = pins_s2_reg.synth_unlock;
    frq_cond_next[FRQ_EXT_BIT] = pins_s2_reg.ext_ref;
    frq_cond_next[FRQ_VCXO_BIT] = pins_s2_reg.vcxo_unlock;
    lim_cond_next = pins_s2_reg.limit_fail;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oper_cond_reg <= REG16_RST;
      dev_cond_reg <= REG16_RST;
      pwr_cond_reg <= REG16_RST;
      frq_cond_reg <= REG16_RST;
      lim_cond_reg <= BYTE_RST;
    end else if (ce_i) begin
      oper_cond_reg <= oper_cond_next;
      dev_cond_reg <= dev_cond_next;
      pwr_cond_reg <= pwr_cond_next;
      frq_cond_reg <= frq_cond_next;
      lim_cond_reg <= lim_cond_next;
    end
  end

  always_comb begin
    oper_set = rising(oper_cond_reg, oper_cond_next);
    oper_set[OPER_AVG_BIT] = avg_done_i;
    dev_set = rising(dev_cond_next, dev_cond_reg);
    pwr_set = rising(pwr_cond_next, pwr_cond_reg);
    frq_set = rising(frq_cond_next, frq_cond_reg);
    lim_set = 8'(rising({8'h00, lim_cond_next},
                        {8'h00, lim_cond_reg}));
  end

  // New edges win over a read or clear in the same cycle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oper_evt_reg <= REG16_RST;
      dev_evt_reg <= REG16_RST;
      pwr_evt_reg <= REG16_RST;
      frq_evt_reg <= REG16_RST;
      lim_evt_reg <= BYTE_RST;
    end else if (ce_i) begin
      oper_evt_reg <= event_next(oper_evt_reg, oper_set,
                                 rd_i.oper | cmd_i.cls);
      dev_evt_reg <= event_next(dev_evt_reg, dev_set,
                                rd_i.dev | cmd_i.cls);
      pwr_evt_reg <= event_next(pwr_evt_reg, pwr_set,
                                rd_i.pwr | cmd_i.cls);
      frq_evt_reg <= event_next(frq_evt_reg, frq_set,
                                rd_i.frq | cmd_i.cls);
      lim_evt_reg <= 8'(event_next({8'h00, lim_evt_reg}, {8'h00, lim_set},
                                   rd_i.lim | cmd_i.cls));
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      oper_en_reg <= EN_RST;
      dev_en_reg <= EN_RST;
      pwr_en_reg <= EN_RST;
      frq_en_reg <= EN_RST;
      lim_en_reg <= EN_RST;
      sre_reg <= BYTE_RST;
    end else if (ce_i && en_wr_i.wr) begin
      unique case (en_wr_i.sel)
        EN_SEL_OPER: oper_en_reg <= en_wr_i.data;
        EN_SEL_DEV: dev_en_reg <= en_wr_i.data;
        EN_SEL_PWR: pwr_en_reg <= en_wr_i.data;
        EN_SEL_FRQ: frq_en_reg <= en_wr_i.data;
        EN_SEL_LIM: lim_en_reg <= en_wr_i.data;
        EN_SEL_SRE: sre_reg <= en_wr_i.data[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      grp_sum_reg <= 3'h0;
    end else if (ce_i) begin
      grp_sum_reg <= {summary(pwr_evt_reg, pwr_en_reg),
                      summary(frq_evt_reg, frq_en_reg),
                      summary({8'h00, lim_evt_reg}, lim_en_reg)};
    end
  end

  // Queue bit is set on a query; a query while it is already set yields no change
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mav_reg <= 1'b0;
    end else if (ce_i) begin
      if (cmd_i.query_rcv) begin
        mav_reg <= 1'b1;
      end else if (cmd_i.resp_out) begin
        mav_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    stb_next = BYTE_RST;
    stb_next[STB_OPER_BIT] = summary(oper_evt_reg, oper_en_reg);
    stb_next[STB_DEV_BIT] = summary(dev_evt_reg, dev_en_reg);
    stb_next[STB_ESB_BIT] = esb_i;
    stb_next[STB_QUESTIONABLE_SUMMARY_BIT_BIT] = questionable_summary_bit_i;
    // Not behind any group mask
    stb_next[STB_MAV_BIT] = mav_reg;
    stb_next[STB_MSS_BIT] = |(stb_next & sre_reg);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stb_reg <= BYTE_RST;
    end else if (ce_i) begin
      stb_reg <= stb_next;
    end
  end

  assign stb_changed = stb_next != stb_reg;
  assign mss_rise = stb_next[STB_MSS_BIT] & ~stb_reg[STB_MSS_BIT];

  // Request state only moves in legacy mode
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      req_reg <= REQ_ON;
    end else if (ce_i && cmd_i.legacy_mode) begin
      if (cmd_i.request_disable_cmd) begin
        req_reg <= REQ_OFF;
      end else if (cmd_i.request_enable_cmd) begin
        req_reg <= REQ_ON;
      end
    end
  end

  always_comb begin
    polled_next = polled_reg;
    if (cmd_i.interp_wr) begin
      polled_next = cmd_i.interp_val;
    end else if (stb_changed) begin
      // Any internal change overrides an unpolled stored value
      polled_next = stb_next;
      polled_next[STB_MSS_BIT] = polled_reg[STB_MSS_BIT];
    end
    if (cmd_i.serial_poll) begin
      polled_next[STB_MSS_BIT] = 1'b0;
    end
    if (cmd_i.legacy_mode && cmd_i.request_disable_cmd) begin
      polled_next[STB_MSS_BIT] = 1'b0;
    end
    // Only a fresh summary or an interpreter write raises the request
    if (mss_rise && (req_reg == REQ_ON || !cmd_i.legacy_mode) &&
        !(cmd_i.legacy_mode && cmd_i.request_disable_cmd)) begin
      polled_next[STB_MSS_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      polled_reg <= BYTE_RST;
    end else if (ce_i) begin
      polled_reg <= polled_next;
    end
  end

  assign oper_cond_o = oper_cond_reg;
  assign oper_evt_o = oper_evt_reg;
  assign dev_cond_o = dev_cond_reg;
  assign dev_evt_o = dev_evt_reg;
  assign pwr_cond_o = pwr_cond_reg;
  assign pwr_evt_o = pwr_evt_reg;
  assign frq_cond_o = frq_cond_reg;
  assign frq_evt_o = frq_evt_reg;
  assign lim_cond_o = lim_cond_reg;
  assign lim_evt_o = lim_evt_reg;
  assign grp_sum_o = grp_sum_reg;
  assign stb_o = stb_reg;
  assign polled_o = polled_reg;
  assign srq_o = polled_reg[STB_MSS_BIT];

  // Checking helpers
  logic [15:0] pwr_rise_chk;
  logic [7:0] lim_rise_chk;
  logic [15:0] frq_rise_chk;
  logic [15:0] oper_hold_chk;
  assign pwr_rise_chk = pwr_cond_next & ~pwr_cond_reg;
  assign lim_rise_chk = lim_cond_next & ~lim_cond_reg;
  assign frq_rise_chk = frq_cond_next & ~frq_cond_reg;
  assign oper_hold_chk = oper_evt_reg;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  property p_oper_cond_map;
    oper_cond_reg[OPER_AVG_BIT] == 1'b0 && oper_cond_reg[15] == 1'b0 &&
      oper_cond_reg[13:9] == 5'h00 && oper_cond_reg[7:4] == 4'h0;
  endproperty
  a_oper_cond_map: assert property (p_oper_cond_map)
    else $error("operation condition has stray bits");

  property p_sweep_end;
    ce_i && oper_cond_reg[OPER_SWEEP_BIT] && !pins_s2_reg.sweeping
      |=> oper_evt_reg[OPER_SWEEP_BIT];
  endproperty
  a_sweep_end: assert property (p_sweep_end)
    else $error("sweep end not latched");

  property p_avg_done;
    ce_i && avg_done_i |=> oper_evt_reg[OPER_AVG_BIT];
  endproperty
  a_avg_done: assert property (p_avg_done)
    else $error("averaging completion not latched");

  property p_pwr_rise;
    ce_i |=> (pwr_evt_reg & $past(pwr_rise_chk)) == $past(pwr_rise_chk);
  endproperty
  a_pwr_rise: assert property (p_pwr_rise)
    else $error("power onset not latched");

  property p_frq_rise;
    ce_i |=> (frq_evt_reg & $past(frq_rise_chk)) == $past(frq_rise_chk);
  endproperty
  a_frq_rise: assert property (p_frq_rise)
    else $error("loss of lock not latched");

  property p_lim_rise;
    ce_i |=> (lim_evt_reg & $past(lim_rise_chk)) == $past(lim_rise_chk);
  endproperty
  a_lim_rise: assert property (p_lim_rise)
    else $error("limit failure not latched");

  property p_evt_hold;
    ce_i && !cmd_i.cls && !rd_i.oper
      |=> (oper_evt_reg & $past(oper_hold_chk)) == $past(oper_hold_chk);
  endproperty
  a_evt_hold: assert property (p_evt_hold)
    else $error("operation event lost without read");

  property p_oper_summary;
    ce_i && |(oper_evt_reg & oper_en_reg) |=> stb_reg[STB_OPER_BIT];
  endproperty
  a_oper_summary: assert property (p_oper_summary)
    else $error("operation summary missing");

  property p_query_mav;
    ce_i && cmd_i.query_rcv |=> mav_reg ##1
      (stb_reg[STB_MAV_BIT] || !$past(ce_i));
  endproperty
  a_query_mav: assert property (p_query_mav)
    else $error("queue bit not raised by query");

  property p_poll_clears;
    ce_i && cmd_i.serial_poll && !cmd_i.interp_wr && !mss_rise
      |=> !polled_reg[STB_MSS_BIT];
  endproperty
  a_poll_clears: assert property (p_poll_clears)
    else $error("serial poll left request set");

  property p_disable_blocks;
    ce_i && cmd_i.legacy_mode && req_reg == REQ_OFF && !cmd_i.interp_wr &&
      !cmd_i.request_enable_cmd && !polled_reg[STB_MSS_BIT]
      |=> !polled_reg[STB_MSS_BIT];
  endproperty
  a_disable_blocks: assert property (p_disable_blocks)
    else $error("request raised while disabled");

  property p_interp_now;
    ce_i && cmd_i.interp_wr |=> polled_reg[7] == $past(cmd_i.interp_val[7]);
  endproperty
  a_interp_now: assert property (p_interp_now)
    else $error("interpreter value not stored at once");

  property p_quiet_keeps;
    ce_i && !stb_changed && !cmd_i.interp_wr
      |=> polled_reg[5:0] == $past(polled_reg[5:0]);
  endproperty
  a_quiet_keeps: assert property (p_quiet_keeps)
    else $error("polled byte moved without internal change");
endmodule // isr_status
`default_nettype wire

// ### isr_ctrl_model.sv
`default_nettype none
module isr_ctrl_model
  import isr_pkg::*;
(
  input wire logic clock_i,
  output var isr_cmd_t cmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] C_CLS = 16'h8000;
  localparam logic [15:0] C_EN = 16'h2000;
  localparam logic [15:0] C_DIS = 16'h1000;
  localparam logic [15:0] C_QRY = 16'h0800;
  localparam logic [15:0] C_RSP = 16'h0400;
  localparam logic [15:0] C_POLL = 16'h0200;
  localparam logic [15:0] C_WR = 16'h0100;
  logic legacy = 1'b0;
  initial begin
    cmd_o = '0;
  end
  // Strobe lasts one cycle; mode level rides along unchanged
  task automatic send(input logic [15:0] c, input logic [7:0] v);
    @(negedge clock_i);
    cmd_o = isr_cmd_t'(c | {8'h00, v} | (legacy ? 16'h4000 : 16'h0000));
    @(negedge clock_i);
    cmd_o = isr_cmd_t'(legacy ? 16'h4000 : 16'h0000);
  endtask
  task automatic set_mode(input logic b);
    @(negedge clock_i);
    legacy = b;
    cmd_o = isr_cmd_t'(b ? 16'h4000 : 16'h0000);
  endtask
  // Request state must be read here before a disable wipes it
  task automatic poll();
    send(C_POLL, 8'h00);
  endtask
  task automatic query();
    send(C_QRY, 8'h00);
  endtask
  task automatic respond();
    send(C_RSP, 8'h00);
  endtask
  task automatic cls();
    send(C_CLS, 8'h00);
  endtask
  task automatic write_byte(input logic [7:0] v);
    send(C_WR, v);
  endtask
  task automatic srq_enable();
    send(C_EN, 8'h00);
  endtask
  task automatic srq_disable();
    send(C_DIS, 8'h00);
  endtask
  // Clear-status alone can leave the polled byte stale
  task automatic clear_all();
    send(C_CLS, 8'h00);
    send(C_WR, 8'h00);
  endtask
endmodule // isr_ctrl_model
`default_nettype wire

// ### tb_top.sv
`default_nettype none
module tb_top
  import isr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i;
  logic rst_i;
  logic ce_i;
  logic avg_done;
  logic esb;
  logic questionable_summary_bit;
  isr_pins_t pins;
  isr_cmd_t cmd;
  isr_rd_t rd;
  isr_en_wr_t en_wr;
  logic [15:0] oper_cond_o, oper_evt_o, dev_cond_o, dev_evt_o;
  logic [15:0] pwr_cond_o, pwr_evt_o, frq_cond_o, frq_evt_o;
  logic [7:0] lim_cond_o, lim_evt_o, stb_o, polled_o;
  logic [2:0] grp_sum_o;
  logic srq_o;
  int fails = 0;
  int total_checks = 0;

  isr_status DUT (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
    .pins_i(pins), .avg_done_i(avg_done), .esb_i(esb), .questionable_summary_bit_i(questionable_summary_bit),
    .cmd_i(cmd), .rd_i(rd), .en_wr_i(en_wr), .oper_cond_o(oper_cond_o),
    .oper_evt_o(oper_evt_o), .dev_cond_o(dev_cond_o),
    .dev_evt_o(dev_evt_o), .pwr_cond_o(pwr_cond_o),
    .pwr_evt_o(pwr_evt_o), .frq_cond_o(frq_cond_o),
    .frq_evt_o(frq_evt_o), .lim_cond_o(lim_cond_o),
    .lim_evt_o(lim_evt_o), .grp_sum_o(grp_sum_o), .stb_o(stb_o),
    .polled_o(polled_o), .srq_o(srq_o));
  isr_ctrl_model ctl (.clock_i(clock_i), .cmd_o(cmd));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic do_reset();
    ctl.set_mode(1'b0);
    rst_i = 1'b1;
    pins = '0;
    cyc(10);
    rst_i = 1'b0;
  endtask
  task automatic en_write(input logic [2:0] sel, input logic [15:0] d);
    @(negedge clock_i);
    en_wr = '{wr: 1'b1, sel: sel, data: d};
    @(negedge clock_i);
    en_wr.wr = 1'b0;
  endtask
  task automatic rd_pulse(input logic [4:0] r);
    @(negedge clock_i);
    rd = isr_rd_t'(r);
    @(negedge clock_i);
    rd = '0;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic t_reset();
    do_reset();
    chk("oper_cond", 16'h0000, oper_cond_o);
    chk("stb", 16'h0000, 16'(stb_o));
    chk("polled", 16'h0000, 16'(polled_o));
    $display("test reset done");
  endtask
  task automatic t_oper();
    do_reset();
    pins.prog_run = 1'b1;
    pins.sweeping = 1'b1;
    pins.calibrating = 1'b1;
    cyc(3);
    chk("oper_cond", 16'h4009, oper_cond_o);
    chk("oper_evt", 16'h0000, oper_evt_o);
    avg_done = 1'b1;
    cyc(1);
    avg_done = 1'b0;
    cyc(1);
    chk("oper_cond", 16'h4009, oper_cond_o);
    chk("oper_evt", 16'h0100, oper_evt_o);
    pins = '0;
    cyc(3);
    chk("oper_evt", 16'h4109, oper_evt_o);
    rd_pulse(5'h10);
    chk("oper_evt", 16'h0000, oper_evt_o);
    $display("test oper done");
  endtask
  task automatic t_groups();
    do_reset();
    pins.overload = 3'h7;
    cyc(3);
    chk("pwr_cond", 16'h0015, pwr_cond_o);
    pins.overload = 3'h0;
    pins.tripped = 3'h7;
    cyc(3);
    chk("pwr_cond", 16'h002A, pwr_cond_o);
    chk("pwr_evt", 16'h003F, pwr_evt_o);
    pins.lo_unlock = 2'h3;
    pins.synth_unlock = 1'b1;
    pins.vcxo_unlock = 1'b1;
    cyc(3);
    chk("frq_cond", 16'h0017, frq_cond_o);
    pins.ext_ref = 1'b1;
    pins.fan_stopped = 1'b1;
    cyc(3);
    chk("frq_cond", 16'h001F, frq_cond_o);
    chk("frq_evt", 16'h001F, frq_evt_o);
    chk("dev_cond", 16'h0001, dev_cond_o);
    for (int i = 0; i < 8; i++) begin
      pins.limit_fail = 8'h01 << i;
      cyc(3);
      chk("lim_cond", 16'(8'h01 << i), 16'(lim_cond_o));
    end
    chk("lim_evt", 16'h00FF, 16'(lim_evt_o));
    en_write(EN_SEL_PWR, 16'h0001);
    en_write(EN_SEL_FRQ, 16'h0010);
    en_write(EN_SEL_LIM, 16'h0080);
    cyc(2);
    chk("grp_sum", 16'h0007, 16'(grp_sum_o));
    en_write(EN_SEL_PWR, 16'h0040);
    cyc(2);
    chk("grp_sum", 16'h0003, 16'(grp_sum_o));
    ctl.cls();
    chk("evt_or", 16'h0000, pwr_evt_o | frq_evt_o | dev_evt_o);
    $display("test groups done");
  endtask
  task automatic t_status();
    do_reset();
    en_write(EN_SEL_DEV, 16'h0001);
    en_write(EN_SEL_OPER, 16'h0008);
    en_write(EN_SEL_SRE, 16'h0084);
    pins.fan_stopped = 1'b1;
    cyc(6);
    chk("stb", 16'h0044, 16'(stb_o));
    chk("polled", 16'h0044, 16'(polled_o));
    ctl.poll();
    chk("srq", 16'h0000, 16'(srq_o));
    chk("polled", 16'h0004, 16'(polled_o));
    chk("stb", 16'h0044, 16'(stb_o));
    ctl.query();
    cyc(3);
    chk("stb", 16'h0054, 16'(stb_o));
    chk("polled", 16'h0014, 16'(polled_o));
    ctl.respond();
    cyc(3);
    chk("stb", 16'h0044, 16'(stb_o));
    pins.sweeping = 1'b1;
    cyc(3);
    pins.sweeping = 1'b0;
    cyc(6);
    chk("stb", 16'h00C4, 16'(stb_o));
    en_write(EN_SEL_OPER, 16'h0000);
    en_write(EN_SEL_DEV, 16'h0000);
    cyc(3);
    chk("stb", 16'h0000, 16'(stb_o));
    ctl.query();
    cyc(3);
    chk("stb", 16'h0010, 16'(stb_o));
    $display("test status done");
  endtask
  task automatic t_interp();
    do_reset();
    ctl.write_byte(8'hC1);
    chk("polled", 16'h00C1, 16'(polled_o));
    chk("srq", 16'h0001, 16'(srq_o));
    ctl.query();
    cyc(3);
    chk("polled", 16'h0050, 16'(polled_o));
    ctl.respond();
    cyc(3);
    ctl.cls();
    cyc(3);
    chk("polled", 16'h0040, 16'(polled_o));
    ctl.clear_all();
    chk("polled", 16'h0000, 16'(polled_o));
    $display("test interp done");
  endtask
  task automatic t_legacy();
    do_reset();
    en_write(EN_SEL_DEV, 16'h0001);
    en_write(EN_SEL_SRE, 16'h0004);
    ctl.set_mode(1'b1);
    ctl.srq_disable();
    pins.fan_stopped = 1'b1;
    cyc(6);
    chk("srq", 16'h0000, 16'(srq_o));
    ctl.srq_enable();
    cyc(3);
    chk("srq", 16'h0000, 16'(srq_o));
    pins.fan_stopped = 1'b0;
    cyc(3);
    rd_pulse(5'h08);
    cyc(3);
    pins.fan_stopped = 1'b1;
    cyc(6);
    chk("srq", 16'h0001, 16'(srq_o));
    ctl.srq_disable();
    ctl.srq_enable();
    cyc(1);
    chk("srq", 16'h0000, 16'(srq_o));
    $display("test legacy done");
  endtask
  task automatic t_ce();
    do_reset();
    esb = 1'b1;
    questionable_summary_bit = 1'b1;
    cyc(2);
    chk("stb", 16'h0028, 16'(stb_o));
    ctl.srq_disable();
    en_write(EN_SEL_SRE, 16'h0020);
    cyc(3);
    chk("srq", 16'h0001, 16'(srq_o));
    ce_i = 1'b0;
    pins.overload = 3'h1;
    ctl.poll();
    cyc(4);
    chk("pwr_cond", 16'h0000, pwr_cond_o);
    chk("srq", 16'h0001, 16'(srq_o));
    ce_i = 1'b1;
    cyc(3);
    chk("pwr_cond", 16'h0001, pwr_cond_o);
    chk("pwr_evt", 16'h0001, pwr_evt_o);
    ctl.poll();
    chk("srq", 16'h0000, 16'(srq_o));
    esb = 1'b0;
    questionable_summary_bit = 1'b0;
    $display("test ce done");
  endtask

  initial begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    avg_done = 1'b0;
    esb = 1'b0;
    questionable_summary_bit = 1'b0;
    pins = '0;
    rd = '0;
    en_wr = '0;
    t_reset();
    t_oper();
    t_groups();
    t_status();
    t_interp();
    t_legacy();
    t_ce();
    end_of_test();
  end
  // Run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    fails++;
    $display("[ERR] watchdog expected finish seen hang");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
